//--- src/priority_resolver.sv
// Purpose: fixed-priority selection among pending interrupt requests
// Assumes: local masks already applied by each source
// Notes:   purely combinational; the caller registers the grant
`timescale 1ns/1ps
`include "rvpu_regs.svh"
module priority_resolver
  import rvpu_pkg::*;
#(
  parameter int NUM_MASKABLE = 15
)(
  input  wire logic [2:0]              nmiReq,
  input  wire logic [NUM_MASKABLE-1:0] maskReq,
  input  wire logic [3:0]              psel,
  input  wire logic                    iMask,
  input  wire logic                    xMask,
  output irq_grant_t                   grant
);
  ////////////////////////////////////////////////////////////////////
  // promotion code to index in the default maskable order
  function automatic logic [3:0] promotedIndex(input logic [3:0] code);
    if (code < 4'h5) begin
      promotedIndex = code + 4'hA;
    end else if (code < 4'h7) begin
      promotedIndex = 4'h0;
    end else begin
      promotedIndex = code - 4'h6;
    end
  endfunction

  // maskable vectors descend by one word per rank
  function automatic logic [15:0] maskVector(input logic [3:0] idx);
    maskVector = `VEC_MASK_TOP - {11'h000, idx, 1'b0};
  endfunction

  logic [3:0] pIdx;                                 // promoted rank
  ////////////////////////////////////////////////////////////////////
  // one selector: nmis, then promoted source, then default order
  always_comb begin
    grant = '0;
    pIdx  = promotedIndex(psel);
    if (nmiReq[0] && !xMask) begin
      grant = '{1'b1, 5'h00, `VEC_PIN_NONMASKABLE_REQUEST};
    end else if (nmiReq[1]) begin
      grant = '{1'b1, 5'h01, `VEC_ILLOP};
    end else if (nmiReq[2]) begin
      grant = '{1'b1, 5'h02, `VEC_SWI};
    end else if (!iMask && maskReq[pIdx]) begin
      // promotion keeps its own vector and masking
      grant = '{1'b1, 5'(pIdx) + 5'h03, maskVector(pIdx)};
    end else if (!iMask) begin
      // descending scan, lowest index left standing wins
      for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
        if (maskReq[i]) begin
          grant = '{1'b1, 5'(i + 3), maskVector(4'(i))};
        end
      end
    end
  end
endmodule

//--- src/reset_vector_priority_unit.sv
// Purpose: reset cause sequencing, restart vector choice, setup and
//          priority registers, watchdog and interrupt arbitration
// Assumes: one clock mclk at 40 MHz, synchronous active-high srst,
//          classic Wishbone slave with 32-bit data, 8-bit registers
// Notes:
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rvpu_regs.svh"
module reset_vector_priority_unit
  import rvpu_pkg::*;
#(
  parameter int         WD_PRESCALE_LOG2 = `WD_PRESCALE_LOG2, // shorten in sims
  parameter int         HOLD_CYCLES      = `HOLD_CYCLES,      // reset hold
  parameter logic [7:0] CONFIG_INIT      = `CONFIG_INIT,      // nonvolatile image
  parameter int         ADDR_W           = 8
)(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic [3:0]        sel_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              resetPinN,
  input  wire logic              modePinA,
  input  wire logic              modePinB,
  input  wire logic              irqPinN,
  input  wire logic              pinNonmaskableRequestN,
  input  wire logic              clockSlow,
  input  wire logic              illegalOpcode,
  input  wire logic              softwareInterrupt,
  input  wire logic [14:1]       periphReq,
  input  wire logic              ccrIMask,
  input  wire logic              ccrXMask,
  input  wire logic              irqAck,
  output logic                   systemReset,
  output logic                   vectorFetch,
  output logic      [15:0]       restartVector,
  output reset_init_t            resetInit,
  output logic                   specialMode,
  output irq_grant_t             irqGrant
);
  localparam int WDW = WD_PRESCALE_LOG2 + 6;   // prescale plus largest rate

  ////////////////////////////////////////////////////////////////////
  // restart vector by cause and mode
  function automatic logic [15:0] vectorFor(input reset_cause_t c,
                                            input logic spec);
    unique case (c)
      CAUSE_PIN:    vectorFor = spec ? `VEC_SPEC_PIN : `VEC_NORM_PIN;
      CAUSE_CLKMON: vectorFor = spec ? `VEC_SPEC_CLKMON : `VEC_NORM_CLKMON;
      CAUSE_WDOG:   vectorFor = spec ? `VEC_SPEC_WDOG : `VEC_NORM_WDOG;
      default:      vectorFor = `VEC_NORM_PIN; // illegal cause code
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: only the stable stage is ever read
  logic [5:0]   pinRaw;                        // raw pin group
  logic [5:0]   syncMeta_reg,   syncMeta_next;
  logic [5:0]   syncStable_reg, syncStable_next;
  logic         rstPinLow;                     // reset pin held low
  logic         modeA, modeB;                  // synced mode pins
  logic         irqLow, xirqLow, clkSlowSync;

  assign pinRaw      = {clockSlow, pinNonmaskableRequestN, irqPinN,
                        modePinB, modePinA, resetPinN};
  assign rstPinLow   = !syncStable_reg[0];
  assign modeA       = syncStable_reg[1];
  assign modeB       = syncStable_reg[2];
  assign irqLow      = !syncStable_reg[3];
  assign xirqLow     = !syncStable_reg[4];
  assign clkSlowSync = syncStable_reg[5];

  // synchroniser next values
  always_comb begin
    syncMeta_next   = pinRaw;
    syncStable_next = syncMeta_reg;
  end

  // synchroniser flops; reset idles pins at their inactive level
  always_ff @(posedge mclk) begin
    if (srst) begin
      syncMeta_reg   <= 6'h1F;
      syncStable_reg <= 6'h1F;
    end else begin
      syncMeta_reg   <= syncMeta_next;
      syncStable_reg <= syncStable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset sequencer state
  seq_state_t   seq_reg,      seq_next;
  reset_cause_t cause_reg,    cause_next;   // latched reset cause
  logic [3:0]   holdCnt_reg,  holdCnt_next; // cycles spent in hold
  logic [1:0]   fetchCnt_reg, fetchCnt_next;
  logic         inHold;                     // registers forced to init
  logic         clkMonReq, wdReq;           // internal reset requests
  logic         wdTimeout;                  // from watchdog group
  logic [7:0]   setup_reg;                  // from register group
  logic         wdEnabled_reg;              // from watchdog group
  logic         special_mode_flag_reg;                   // from register group

  assign inHold    = (seq_reg == ST_HOLD);
  assign clkMonReq = setup_reg[`SU_CLK_MON] && clkSlowSync;
  assign wdReq     = wdEnabled_reg && wdTimeout;

  // next state: hold, three fetch cycles, then run
  always_comb begin
    seq_next      = seq_reg;
    cause_next    = cause_reg;
    holdCnt_next  = holdCnt_reg;
    fetchCnt_next = fetchCnt_reg;
    unique case (seq_reg)
      ST_HOLD: begin
        if (rstPinLow) begin
          cause_next = CAUSE_PIN;
        end
        if (holdCnt_reg != 4'(HOLD_CYCLES - 1)) begin
          holdCnt_next = holdCnt_reg + 4'h1;
        end else if (!rstPinLow) begin
          // release edge of reset
          seq_next      = ST_FETCH;
          fetchCnt_next = 2'h0;
        end
      end
      ST_FETCH, ST_RUN: begin
        if (seq_reg == ST_FETCH && fetchCnt_reg != `FETCH_CYCLES - 2'h1) begin
          fetchCnt_next = fetchCnt_reg + 2'h1;
        end else if (seq_reg == ST_FETCH) begin
          seq_next = ST_RUN;
        end
        // pin beats clock monitor beats watchdog
        if (rstPinLow || clkMonReq || wdReq) begin
          seq_next     = ST_HOLD;
          holdCnt_next = 4'h0;
          cause_next   = rstPinLow ? CAUSE_PIN :
                         (clkMonReq ? CAUSE_CLKMON : CAUSE_WDOG);
        end
      end
      default: begin
        // illegal code falls back to a fresh hold
        seq_next     = ST_HOLD;
        holdCnt_next = 4'h0;
      end
    endcase
  end

  // sequencer flops; srst is the power-on cause
  always_ff @(posedge mclk) begin
    if (srst) begin
      seq_reg      <= ST_HOLD;
      cause_reg    <= CAUSE_PIN;
      holdCnt_reg  <= 4'h0;
      fetchCnt_reg <= 2'h0;
    end else begin
      seq_reg      <= seq_next;
      cause_reg    <= cause_next;
      holdCnt_reg  <= holdCnt_next;
      fetchCnt_reg <= fetchCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register file and Wishbone slave
  logic [7:0]   setup_next;
  logic [7:0]   config_reg,  config_next;  // survives internal resets
  logic         boot_reg,    boot_next;
  logic         special_mode_flag_next;
  logic         mda_reg,     mda_next;
  logic         irvne_reg,   irvne_next;
  logic [3:0]   psel_reg,    psel_next;
  logic [6:0]   window_reg,  window_next;  // cycles since reset release
  logic         protUsed_reg, protUsed_next;
  logic         ack_reg,     ack_next;
  logic [7:0]   rdata_reg,   rdata_next;
  logic         access, wrHit;             // bus strobes
  logic [7:0]   wmask;                     // writable setup bits now
  logic [7:0]   status;                    // live status byte
  logic         irqEdge_reg;               // from watchdog group
  logic         irqPending;                // from watchdog group

  assign access = cyc_i && stb_i && !ack_reg;
  assign wrHit  = access && we_i && sel_i[0];
  assign status = {2'h0, protUsed_reg, wdEnabled_reg, cause_reg,
                   irqPending, irqEdge_reg};

  // register updates, reset values applied while holding
  always_comb begin
    setup_next    = setup_reg;
    config_next   = config_reg;
    boot_next     = boot_reg;
    special_mode_flag_next     = special_mode_flag_reg;
    mda_next      = mda_reg;
    irvne_next    = irvne_reg;
    psel_next     = psel_reg;
    window_next   = window_reg;
    protUsed_next = protUsed_reg;
    ack_next      = access;
    rdata_next    = rdata_reg;
    wmask         = `SETUP_IMPL_MASK & ~`SETUP_PROT_MASK;
    if (special_mode_flag_reg || (!protUsed_reg && window_reg < `PROT_WINDOW)) begin
      wmask = `SETUP_IMPL_MASK;
    end
    if (inHold) begin
      // converter off, monitor off, level irq, shortest rate
      setup_next    = `SETUP_RESET;
      psel_next     = `PSEL_RESET;
      window_next   = 7'h00;
      protUsed_next = 1'b0;
      boot_next     = 1'b0;
      special_mode_flag_next     = 1'b0;
      mda_next      = 1'b0;
      irvne_next    = 1'b0;
      if (seq_next == ST_FETCH) begin
        // capture mode pins at the release edge
        special_mode_flag_next  = !modeB;
        mda_next   = modeA;
        boot_next  = !modeB && !modeA;
        irvne_next = !modeB && modeA;
      end
    end else begin
      if (window_reg != `PROT_WINDOW) begin
        window_next = window_reg + 7'h01;
      end
      if (wrHit && adr_i == ADDR_W'(`OFS_SETUP)) begin
        // bit 2 never stored
        setup_next = (setup_reg & ~wmask) | (dat_i[7:0] & wmask);
        if (!special_mode_flag_reg && (wmask & `SETUP_PROT_MASK) != 8'h00) begin
          protUsed_next = 1'b1;
        end
      end
      if (wrHit && adr_i == ADDR_W'(`OFS_CONFIG)) begin
        config_next = dat_i[7:0];
      end
      if (wrHit && adr_i == ADDR_W'(`OFS_PRIO)) begin
        irvne_next = dat_i[`PR_IRVNE];
        if (ccrIMask) begin
          psel_next = dat_i[3:0];
        end
        if (special_mode_flag_reg) begin
          // mode change only from special modes
          special_mode_flag_next = dat_i[`PR_SPECIAL_MODE_FLAG];
          mda_next  = dat_i[`PR_MDA];
          boot_next = dat_i[`PR_BOOT];
        end
      end
    end
    if (access && !we_i) begin
      unique case (adr_i)
        ADDR_W'(`OFS_SETUP):  rdata_next = setup_reg & `SETUP_IMPL_MASK;
        ADDR_W'(`OFS_CONFIG): rdata_next = config_reg;
        ADDR_W'(`OFS_PRIO):   rdata_next = {boot_reg, special_mode_flag_reg, mda_reg,
                                            irvne_reg, psel_reg};
        ADDR_W'(`OFS_STATUS): rdata_next = status;
        default:              rdata_next = 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // register flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      setup_reg    <= `SETUP_RESET;
      config_reg   <= CONFIG_INIT;
      boot_reg     <= 1'b0;
      special_mode_flag_reg     <= 1'b0;
      mda_reg      <= 1'b0;
      irvne_reg    <= 1'b0;
      psel_reg     <= `PSEL_RESET;
      window_reg   <= 7'h00;
      protUsed_reg <= 1'b0;
      ack_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
    end else begin
      setup_reg    <= setup_next;
      config_reg   <= config_next;
      boot_reg     <= boot_next;
      special_mode_flag_reg     <= special_mode_flag_next;
      mda_reg      <= mda_next;
      irvne_reg    <= irvne_next;
      psel_reg     <= psel_next;
      window_reg   <= window_next;
      protUsed_reg <= protUsed_next;
      ack_reg      <= ack_next;
      rdata_reg    <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // watchdog, irq pin conditioning and registered outputs
  logic [WDW-1:0] wdCnt_reg,   wdCnt_next;
  logic [WDW-1:0] wdLimit;                  // last count before timeout
  logic           wdArmed_reg, wdArmed_next;
  logic           wdEnabled_next;
  logic           irqEdge_next;
  logic           irqPrev_reg, irqPrev_next; // previous synced irq level
  logic           wdSvc;                     // service register write
  irq_grant_t     grantComb;                 // resolver result
  logic           sysRst_next, fetch_next;
  logic [15:0]    vector_next;
  irq_grant_t     grant_next;

  // shift by the prescale plus two bits per rate step
  assign wdLimit   = ~({WDW{1'b1}} << (WD_PRESCALE_LOG2 + 2 * int'(setup_reg[1:0])));
  assign wdTimeout = (wdCnt_reg == wdLimit);
  assign wdSvc     = wrHit && adr_i == ADDR_W'(`OFS_WDSVC);
  assign irqPending = setup_reg[`SU_IRQ_EDGE] ? irqEdge_reg : irqLow;

  priority_resolver #(
    .NUM_MASKABLE (15)
  ) resolver (
    .nmiReq  ({softwareInterrupt, illegalOpcode, xirqLow}),
    .maskReq ({periphReq, irqPending}),
    .psel    (psel_reg),
    .iMask   (ccrIMask),
    .xMask   (ccrXMask),
    .grant   (grantComb)
  );

  // watchdog count, service sequence, edge latch, outputs
  always_comb begin
    wdCnt_next     = wdCnt_reg + {{(WDW-1){1'b0}}, 1'b1};
    wdArmed_next   = wdArmed_reg;
    wdEnabled_next = wdEnabled_reg;
    irqPrev_next   = irqLow;
    // a falling edge in the ack cycle is kept
    irqEdge_next   = (irqLow && !irqPrev_reg) || (irqEdge_reg && !irqAck);
    if (wdSvc && dat_i[7:0] == `WDSVC_ARM) begin
      wdArmed_next = 1'b1;
    end else if (wdSvc && dat_i[7:0] == `WDSVC_CLEAR && wdArmed_reg) begin
      wdArmed_next = 1'b0;
      wdCnt_next   = '0;
    end
    if (inHold) begin
      wdCnt_next     = '0;
      wdArmed_next   = 1'b0;
      irqEdge_next   = 1'b0;
      wdEnabled_next = !config_reg[`CFG_WD_DIS];
    end
    sysRst_next = (seq_next == ST_HOLD);
    fetch_next  = (seq_next == ST_FETCH);
    vector_next = vectorFor(cause_next, special_mode_flag_next);
    grant_next  = sysRst_next ? '0 : grantComb;
  end

  // fixed values forced while reset holds
  localparam reset_init_t INIT_VALUES = '{
    ccrXMask:      1'b1,
    ccrIMask:      1'b1,
    ccrStopDis:    1'b1,
    memPlacement:  `INIT_MEMMAP,
    timerCount:    `INIT_TIMER,
    compareInit:   `INIT_COMPARE,
    serialBaud:    `INIT_BAUD,
    txDataEmpty:   1'b1,
    txComplete:    1'b1,
    serialNineBit: 1'b0
  };

  // watchdog and output flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      wdCnt_reg     <= '0;
      wdArmed_reg   <= 1'b0;
      wdEnabled_reg <= 1'b0;
      irqEdge_reg   <= 1'b0;
      irqPrev_reg   <= 1'b0;
      systemReset   <= 1'b1;
      vectorFetch   <= 1'b0;
      restartVector <= `VEC_NORM_PIN;
      resetInit     <= INIT_VALUES;
      specialMode   <= 1'b0;
      irqGrant      <= '0;
    end else begin
      wdCnt_reg     <= wdCnt_next;
      wdArmed_reg   <= wdArmed_next;
      wdEnabled_reg <= wdEnabled_next;
      irqEdge_reg   <= irqEdge_next;
      irqPrev_reg   <= irqPrev_next;
      // peripherals clear flags, masks, rates, enables on this level
      systemReset   <= sysRst_next;
      vectorFetch   <= fetch_next;
      restartVector <= vector_next;
      resetInit     <= INIT_VALUES;
      specialMode   <= special_mode_flag_next;
      irqGrant      <= grant_next;
    end
  end

  assign dat_o = {24'h000000, rdata_reg};
  assign ack_o = ack_reg;
endmodule

//--- src/rvpu_pkg.sv
// Purpose: shared types of the reset and priority unit
// Assumes: nothing
// Notes:   constants live in rvpu_regs.svh
package rvpu_pkg;
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN   = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    CAUSE_PIN    = 2'b00,
    CAUSE_CLKMON = 2'b01,
    CAUSE_WDOG   = 2'b10
  } reset_cause_t;
  // values forced on cpu and peripherals while reset holds
  typedef struct packed {
    logic        ccrXMask;
    logic        ccrIMask;
    logic        ccrStopDis;
    logic [7:0]  memPlacement;
    logic [15:0] timerCount;
    logic [15:0] compareInit;
    logic [7:0]  serialBaud;
    logic        txDataEmpty;
    logic        txComplete;
    logic        serialNineBit;
  } reset_init_t;
  // winning interrupt: source 0 pin_nonmaskable_request, 1 illegal, 2 swi, 3.. maskable
  typedef struct packed {
    logic        valid;
    logic [4:0]  source;
    logic [15:0] vector;
  } irq_grant_t;
endpackage

//--- src/rvpu_regs.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes:   definitions only
`ifndef RVPU_REGS_SVH
`define RVPU_REGS_SVH
// register byte offsets
`define OFS_SETUP        8'h00
`define OFS_CONFIG       8'h04
`define OFS_PRIO         8'h08
`define OFS_WDSVC        8'h0C
`define OFS_STATUS       8'h10
// setup register fields
`define SU_CONV_PWR      7
`define SU_CONV_CLK      6
`define SU_IRQ_EDGE      5
`define SU_STOP_DLY      4
`define SU_CLK_MON       3
`define SETUP_RESET      8'h10
`define SETUP_IMPL_MASK  8'hFB
`define SETUP_PROT_MASK  8'h33
// configuration fields
`define CFG_WD_DIS       2
`define CONFIG_INIT      8'h0B
// priority and mode register fields
`define PR_BOOT          7
`define PR_SPECIAL_MODE_FLAG          6
`define PR_MDA           5
`define PR_IRVNE         4
`define PSEL_RESET       4'h6
// counts in mclk cycles
`define PROT_WINDOW      7'h40
`define FETCH_CYCLES     2'h3
`define HOLD_CYCLES      4
`define WD_PRESCALE_LOG2 15
// watchdog service keys
`define WDSVC_ARM        8'h55
`define WDSVC_CLEAR      8'hAA
// restart vectors
`define VEC_NORM_PIN     16'hFFFE
`define VEC_NORM_CLKMON  16'hFFFC
`define VEC_NORM_WDOG    16'hFFFA
`define VEC_SPEC_PIN     16'hBFFE
`define VEC_SPEC_CLKMON  16'hBFFC
`define VEC_SPEC_WDOG    16'hBFFA
// interrupt vectors
`define VEC_PIN_NONMASKABLE_REQUEST         16'hFFF4
`define VEC_SWI          16'hFFF6
`define VEC_ILLOP        16'hFFF8
`define VEC_MASK_TOP     16'hFFF2
// peripheral initial values
`define INIT_MEMMAP      8'h01
`define INIT_TIMER       16'h0000
`define INIT_COMPARE     16'hFFFF
`define INIT_BAUD        8'h04
`endif

//--- testbench/cpu_source_model.sv
// Purpose: cpu masks and peripheral request sources
// Assumes: same clock as the unit
// Notes:   bench steers it through drive
`timescale 1ns/1ps
module cpu_source_model
  import rvpu_pkg::*;
(
  input wire logic    mclk,
  input irq_grant_t   irqGrant,
  output logic        illegalOpcode, softwareInterrupt, ccrIMask, ccrXMask, irqAck,
  output logic [14:1] periphReq
);
  // cpu leaves reset with both masks set
  initial {illegalOpcode, softwareInterrupt, ccrIMask, ccrXMask, periphReq} = 18'h0C000;
  // pin grant seen: clear its latch
  always @(posedge mclk) irqAck <= irqGrant.valid && irqGrant.source == 5'h03;
  // mask is clear for the bench's second priority field write, so psel keeps 09; both masks move together
  task automatic drive(input logic ill, input logic sw, input logic [14:1] req, input logic im);
    @(posedge mclk);
    {illegalOpcode, softwareInterrupt, periphReq} <= {ill, sw, req};
    ccrIMask <= im;
    ccrXMask <= im;
  endtask
endmodule

//--- testbench/rvpu_properties.sv
// Purpose: port checks of the reset and priority unit
// Assumes: one clock, srst synchronous
// Notes:   bound to the unit below
`timescale 1ns/1ps
module rvpu_properties
  import rvpu_pkg::*;
(
  input wire logic        mclk, srst, cyc_i, stb_i, ack_o, systemReset,
  input wire logic        vectorFetch, specialMode, ccrIMask, illegalOpcode,
  input wire logic [15:0] restartVector,
  input reset_init_t      resetInit,
  input irq_grant_t       irqGrant
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_fetch; $rose(vectorFetch) |-> vectorFetch[*3] ##1 !vectorFetch; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch length wrong");
  property p_hold; $fell(systemReset) |-> $rose(vectorFetch); endproperty
  a_hold: assert property (p_hold) else $error("no fetch after hold");
  property p_norm; vectorFetch && !specialMode |-> restartVector inside {16'hFFFE, 16'hFFFC, 16'hFFFA}; endproperty
  a_norm: assert property (p_norm) else $error("bad restart vector");
  property p_init; systemReset |-> resetInit.memPlacement == 8'h01 && resetInit.compareInit == 16'hFFFF; endproperty
  a_init: assert property (p_init) else $error("bad init values");
  property p_mask; irqGrant.valid && irqGrant.source >= 5'h03 |-> !$past(ccrIMask); endproperty
  a_mask: assert property (p_mask) else $error("masked grant");
  property p_vec; irqGrant.valid && irqGrant.source >= 5'h03 |->
    irqGrant.vector == 16'hFFF2 - 16'({irqGrant.source - 5'h03, 1'b0}); endproperty
  a_vec: assert property (p_vec) else $error("vector moved");
  property p_nmi; $past(illegalOpcode) && !$past(systemReset) && !systemReset |->
    irqGrant.valid && irqGrant.source <= 5'h01; endproperty
  a_nmi: assert property (p_nmi) else $error("trap outranked");
  c_fetch: cover property ($rose(vectorFetch));
  c_prom: cover property (irqGrant.valid && irqGrant.source == 5'h06);
  c_trap: cover property (irqGrant.valid && irqGrant.source == 5'h01);
endmodule
bind reset_vector_priority_unit rvpu_properties u_props (.mclk, .srst, .cyc_i, .stb_i, .ack_o, .systemReset,
  .vectorFetch, .specialMode, .ccrIMask, .illegalOpcode, .restartVector, .resetInit, .irqGrant);

//--- testbench/testbench.sv
// Purpose: directed bench of the reset and priority unit
// Assumes: 40 MHz mclk, short watchdog prescale
// Notes:   watchdog held off until the last step
`timescale 1ns/1ps
module testbench
  import rvpu_pkg::*;
;
  logic        mclk, srst, cyc_i, stb_i, we_i, ack_o, clockSlow, ill, sw, im, xm, iack, sysRst, fetch, special;
  logic        rstN, irqN, xirqN, modeB;
  logic [7:0]  adr_i, q;
  logic [31:0] dat_i, dat_o;
  logic [3:0]  sel_i;
  logic [14:1] req;
  logic [15:0] vec;
  irq_grant_t  grant;
  int          fail_count, compares;
  reset_vector_priority_unit #(.WD_PRESCALE_LOG2(6), .CONFIG_INIT(8'h0F)) uut (.mclk, .srst, .cyc_i, .stb_i,
    .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .resetPinN(rstN), .modePinA(1'b0), .modePinB(modeB),
    .irqPinN(irqN), .pinNonmaskableRequestN(xirqN), .clockSlow, .illegalOpcode(ill), .softwareInterrupt(sw),
    .periphReq(req), .ccrIMask(im), .ccrXMask(xm), .irqAck(iack), .systemReset(sysRst), .vectorFetch(fetch),
    .restartVector(vec), .resetInit(), .specialMode(special), .irqGrant(grant));
  cpu_source_model cpu (.mclk, .irqGrant(grant), .illegalOpcode(ill), .softwareInterrupt(sw),
    .periphReq(req), .ccrIMask(im), .ccrXMask(xm), .irqAck(iack));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for a high level at a clock edge
  task automatic waitHi(ref logic s);
    int n;
    n = 0;
    do begin @(posedge mclk); n++; end while (s !== 1'b1 && n < 500);
    if (s !== 1'b1) begin fail_count++; give_verdict; end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, 24'h000000, d, 4'h1};
    waitHi(ack_o);
    q = dat_o[7:0];
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {srst, cyc_i, stb_i, we_i, clockSlow, adr_i, dat_i, sel_i} = {5'b10000, 44'h0};
    {rstN, irqN, xirqN, modeB} = 4'hF;
    fail_count = 0;
    compares = 0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    waitHi(fetch);
    chk(vec, 16'hFFFE);
    chk(special, 1'b0);
    rd(8'h00, 8'h10);
    rd(8'h08, 8'h06);
    wb(1'b1, 8'h00, 8'hFF);
    rd(8'h00, 8'hFB);
    wb(1'b1, 8'h00, 8'h00);
    rd(8'h00, 8'h33);
    wb(1'b1, 8'h08, 8'h09);
    rd(8'h08, 8'h09);
    cpu.drive(1'b0, 1'b0, 14'h0005, 1'b0);
    wb(1'b1, 8'h08, 8'h07);
    rd(8'h08, 8'h09);
    chk(grant, {1'b1, 5'h06, 16'hFFEC});
    cpu.drive(1'b1, 1'b1, 14'h0005, 1'b0);
    repeat (2) @(posedge mclk);
    chk(grant, {1'b1, 5'h01, 16'hFFF8});
    cpu.drive(1'b0, 1'b0, 14'h0005, 1'b1);
    repeat (2) @(posedge mclk);
    chk(grant.valid, 1'b0);
    wb(1'b1, 8'h00, 8'h08);
    clockSlow <= 1'b1;
    waitHi(fetch);
    chk(vec, 16'hFFFC);
    clockSlow <= 1'b0;
    rd(8'h00, 8'h10);
    // irq pin held low in level mode, promoted by the reset priority code
    cpu.drive(1'b0, 1'b0, 14'h0005, 1'b0);
    irqN <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(grant, {1'b1, 5'h03, 16'hFFF2});
    // edge-only mode ignores the level that is still held
    wb(1'b1, 8'h00, 8'h20);
    repeat (2) @(posedge mclk);
    chk(grant, {1'b1, 5'h04, 16'hFFF0});
    xirqN <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(grant, {1'b1, 5'h00, 16'hFFF4});
    {irqN, xirqN} <= 2'b11;
    cpu.drive(1'b0, 1'b0, 14'h0000, 1'b1);
    wb(1'b1, 8'h04, 8'h0B);
    // pin reset into a special mode; the config image survives it
    rstN <= 1'b0;
    modeB <= 1'b0;
    repeat (4) @(posedge mclk);
    rstN <= 1'b1;
    waitHi(fetch);
    chk(vec, 16'hBFFE);
    chk(special, 1'b1);
    modeB <= 1'b1;
    rd(8'h10, 8'h10);
    waitHi(sysRst);
    waitHi(fetch);
    chk(vec, 16'hFFFA);
    rd(8'h10, 8'h18);
    give_verdict;
  end
endmodule
